// ===== t2c_pkg.sv
// package: register map, field positions and carriers for the timer2 control block
package t2c_pkg;

  // ==========================================================================
  // register map (byte addresses; control and mode sit one byte apart, the others one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_CONTROL  = 8'hC8;
  localparam logic [7:0] ADDR_MODE     = 8'hC9;
  localparam logic [7:0] ADDR_COUNT    = 8'hCC;
  localparam logic [7:0] ADDR_HOLD     = 8'hD0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hD4;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'hD8;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'hDC;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int BIT_OVF    = 7;
  localparam int BIT_EXF    = 6;
  localparam int BIT_RXBAUD = 5;
  localparam int BIT_TXBAUD = 4;
  localparam int BIT_EXEN   = 3;
  localparam int BIT_RUN    = 2;
  localparam int BIT_CSRC   = 1;
  localparam int BIT_CPRL   = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // mode register: bit 0 down count enable
  localparam int BIT_DOWN_COUNT_ENABLE = 0;

  // interrupt status bits
  localparam int IRQ_OVF  = 0;
  localparam int IRQ_EXT  = 1;
  localparam int IRQ_BITS = 2;

  // prescaler cycle counts
  localparam logic [3:0] DIV_6CLK  = 4'h6;
  localparam logic [3:0] DIV_12CLK = 4'hC;

  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } t2c_baud_s;

  typedef struct packed {
    logic overflow_pulse;
    logic trigger_pulse;
  } t2c_event_s;

endpackage

// ===== t2c_sync.sv
// three-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
module t2c_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // ==========================================================================
  // a change counts only once stages two and three agree
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
      fall    <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fall <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        fall    <= level_q & ~s3_q;
      end
    end
  end

endmodule

// ===== t2c_timer.sv
// timer2 counter with capture/reload, baud tick routing and avalon-mm registers
// ==========================================================================
// Notes on behaviour
// - counter overflow with neither baud bit set sets the overflow flag, bit 7; only software zero clears.
// - trigger-pin falling edge causing capture or reload sets external flag, bit 6.
// - external flag set requests the timer interrupt when that interrupt is enabled.
// - with down count enable set the external flag raises no interrupt; the code masks timer_irq_req only, trigger edges still raise irq.
// - hardware never clears the external flag; software writes zero.
// - bit 5 set sends overflow pulses as the serial receive clock.
// - bit 4 set sends overflow pulses as the serial transmit clock.
// - trigger enable, bit 3, gates trigger-pin edges; ignored when clocking serial port.
// - source select zero counts oscillator divided by 6 or 12.
// - source select one counts falling edges of the external count input.
// - capture select set with trigger enable captures count on trigger edges.
// - capture select clear reloads on overflow and on enabled trigger edges.
// - either baud bit set forces reload on overflow, ignoring capture select.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module t2c_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pins and system
  input  wire logic        external_trigger_pin,
  input  wire logic        count_pin,
  input  wire logic        six_clock_mode,
  input  wire logic        timer_irq_enable,
  // outputs
  output logic             timer_irq_req,
  output logic             irq,
  output t2c_pkg::t2c_baud_s baud_q
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [7:0]       control_q;
  logic             down_count_enable_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] hold_q;
  logic [3:0]       presc_q;
  logic [t2c_pkg::IRQ_BITS-1:0] irq_stat_q;
  logic [t2c_pkg::IRQ_BITS-1:0] irq_en_q;
  logic             ack_q;
  t2c_pkg::t2c_event_s ev;

  logic trig_fall;
  logic cnt_fall;

  t2c_sync u_trig_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (external_trigger_pin),
    .fall    (trig_fall)
  );

  t2c_sync u_cnt_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (count_pin),
    .fall    (cnt_fall)
  );

  // ==========================================================================
  // derived control
  // ==========================================================================
  logic baud_mode;
  logic tick;
  logic ovf;
  logic trig_event;
  logic capture_mode;
  logic [3:0] div_last;

  assign baud_mode    = control_q[t2c_pkg::BIT_RXBAUD] | control_q[t2c_pkg::BIT_TXBAUD];
  assign capture_mode = control_q[t2c_pkg::BIT_CPRL] & ~baud_mode;
  assign div_last     = six_clock_mode ? t2c_pkg::DIV_6CLK - 4'h1 : t2c_pkg::DIV_12CLK - 4'h1;

  always_comb begin
    tick = 1'b0;
    if (control_q[t2c_pkg::BIT_RUN]) begin
      if (control_q[t2c_pkg::BIT_CSRC]) begin
        tick = cnt_fall;
      end else begin
        tick = (presc_q == div_last);
      end
    end
  end

  assign ovf = tick & (count_q == {CNT_W{1'b1}});
  // trigger edges only act when enabled and timer is not a baud source
  assign trig_event = trig_fall & control_q[t2c_pkg::BIT_EXEN] & ~baud_mode;
  assign ev.overflow_pulse = ovf;
  assign ev.trigger_pulse  = trig_event;

  // ==========================================================================
  // prescaler
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      presc_q <= 4'h0;
    end else if (!control_q[t2c_pkg::BIT_RUN] || presc_q >= div_last) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  // ==========================================================================
  // counter and holding register
  // ==========================================================================
  logic bus_wr;
  logic bus_rd;
  // a write lands at the answer edge, the only edge at which the master sees waitrequest low
  assign bus_wr = avs_write & ack_q;
  assign bus_rd = avs_read & ~ack_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_q <= t2c_pkg::COUNT_RESET;
      hold_q  <= t2c_pkg::COUNT_RESET;
    end else begin
      if (bus_wr && avs_address == t2c_pkg::ADDR_HOLD) begin
        hold_q <= avs_writedata[CNT_W-1:0];
      end else if (trig_event && capture_mode) begin
        hold_q <= count_q;
      end
      if (bus_wr && avs_address == t2c_pkg::ADDR_COUNT) begin
        count_q <= avs_writedata[CNT_W-1:0];
      end else if (ovf && !capture_mode) begin
        count_q <= hold_q;
      end else if (trig_event && !capture_mode) begin
        count_q <= hold_q;
      end else if (tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // control register: hardware set wins over software clear
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control_q <= t2c_pkg::CONTROL_RESET;
      down_count_enable_q    <= 1'b0;
    end else begin
      if (bus_wr && avs_address == t2c_pkg::ADDR_CONTROL && avs_byteenable[0]) begin
        control_q <= avs_writedata[7:0];
      end
      if (bus_wr && avs_address == t2c_pkg::ADDR_MODE && avs_byteenable[0]) begin
        down_count_enable_q <= avs_writedata[t2c_pkg::BIT_DOWN_COUNT_ENABLE];
      end
      if (ovf && !baud_mode) begin
        control_q[t2c_pkg::BIT_OVF] <= 1'b1;
      end
      // flag stays until software writes zero
      if (trig_event) begin
        control_q[t2c_pkg::BIT_EXF] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // baud ticks to the serial port
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      baud_q <= '0;
    end else begin
      baud_q.rx_tick <= ovf & control_q[t2c_pkg::BIT_RXBAUD];
      baud_q.tx_tick <= ovf & control_q[t2c_pkg::BIT_TXBAUD];
    end
  end

  // ==========================================================================
  // timer interrupt request and system event interrupts
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_irq_req <= 1'b0;
    end else begin
      timer_irq_req <= timer_irq_enable &
                       (control_q[t2c_pkg::BIT_OVF] |
                        (control_q[t2c_pkg::BIT_EXF] & ~down_count_enable_q));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
    end else begin
      if (bus_wr && avs_address == t2c_pkg::ADDR_IRQ_EN) begin
        irq_en_q <= avs_writedata[t2c_pkg::IRQ_BITS-1:0];
      end
      // set wins over a simultaneous clear
      if (bus_wr && avs_address == t2c_pkg::ADDR_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata[t2c_pkg::IRQ_BITS-1:0]) |
                      {ev.trigger_pulse, ev.overflow_pulse};
      end else begin
        irq_stat_q <= irq_stat_q | {ev.trigger_pulse, ev.overflow_pulse};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ==========================================================================
  // avalon-mm: one wait state, answer on the second edge
  // ==========================================================================
  // waitrequest is kept as its own flop, always the inverse of ack_q, so the port comes straight from a register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      if (avs_address == t2c_pkg::ADDR_CONTROL) begin
        avs_readdata <= {24'h00_0000, control_q};
      end else if (avs_address == t2c_pkg::ADDR_MODE) begin
        avs_readdata <= {31'h0000_0000, down_count_enable_q};
      end else if (avs_address == t2c_pkg::ADDR_COUNT) begin
        avs_readdata <= 32'(count_q);
      end else if (avs_address == t2c_pkg::ADDR_HOLD) begin
        avs_readdata <= 32'(hold_q);
      end else if (avs_address == t2c_pkg::ADDR_IRQ_STAT) begin
        avs_readdata <= 32'(irq_stat_q);
      end else if (avs_address == t2c_pkg::ADDR_IRQ_EN) begin
        avs_readdata <= 32'(irq_en_q);
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ===== t2c_timer_sva.sv
// checker: bus handshake, interrupt level and baud tick relations at the timer ports
`timescale 1ns/1ps
module t2c_timer_sva #(
  parameter int CNT_W = 16
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire logic [7:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic [3:0]   avs_byteenable,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  input wire logic         external_trigger_pin,
  input wire logic         count_pin,
  input wire logic         six_clock_mode,
  input wire logic         timer_irq_enable,
  input wire logic         timer_irq_req,
  input wire logic         irq,
  input t2c_pkg::t2c_baud_s baud_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // bus handshake
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer missing one cycle after request");
  property p_idle;
    !avs_read && !avs_write |-> avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  property p_clr_reads_zero;
    avs_read && !avs_waitrequest && avs_address == t2c_pkg::ADDR_IRQ_CLR |-> avs_readdata == 32'h0;
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("write-only clear register read nonzero");
  // ==========================================================================
  // ticks and interrupts
  property p_rx_pulse;
    baud_q.rx_tick |=> !baud_q.rx_tick;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive tick longer than one cycle");
  property p_tx_pulse;
    baud_q.tx_tick |=> !baud_q.tx_tick;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit tick longer than one cycle");
  property p_req_gate;
    !timer_irq_enable |=> !timer_irq_req;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("timer request without enable");
  // flags only fall after a bus write, so the request must hold without one
  property p_req_sticky;
    timer_irq_req && timer_irq_enable && !$past(avs_write) |=> timer_irq_req;
  endproperty
  a_req_sticky: assert property (p_req_sticky) else $error("timer request dropped without write");
  property p_irq_sticky;
    irq && !$past(avs_write) |=> irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without write");
endmodule
bind t2c_timer t2c_timer_sva #(.CNT_W(CNT_W)) sva_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_trigger_pin(external_trigger_pin),
  .count_pin(count_pin), .six_clock_mode(six_clock_mode), .timer_irq_enable(timer_irq_enable),
  .timer_irq_req(timer_irq_req), .irq(irq), .baud_q(baud_q));

// ===== t2c_far.sv
// far side model: trigger source, external count source and serial port tick counter
`timescale 1ns/1ps
module t2c_far (
  input wire logic          ref_clk,
  input wire logic          trig_go,
  input wire logic          cnt_run,
  input t2c_pkg::t2c_baud_s baud_q,
  output logic              trig_pin,
  output logic              cnt_pin,
  output int                rx_ticks,
  output int                tx_ticks
);
  int trig_left;
  int cnt_div;
  initial begin
    trig_pin  = 1'b1;
    cnt_pin   = 1'b1;
    trig_left = 0;
    cnt_div   = 0;
    rx_ticks  = 0;
    tx_ticks  = 0;
  end
  // pins idle high as if pulled up; a low of 8 cycles outlasts the synchroniser
  always @(posedge ref_clk) begin
    trig_left <= trig_go ? 8 : (trig_left > 0 ? trig_left - 1 : 0);
    trig_pin  <= !(trig_go || trig_left > 1);
    cnt_div   <= cnt_run ? cnt_div + 1 : 0;
    cnt_pin   <= cnt_run ? cnt_div[2] : 1'b1;
    rx_ticks  <= rx_ticks + int'(baud_q.rx_tick);
    tx_ticks  <= tx_ticks + int'(baud_q.tx_tick);
  end
endmodule

// ===== tb_timer2_control_capture_reload.sv
// testbench: register, capture, reload, baud and interrupt scenarios for the timer block
`timescale 1ns/1ps
module tb_timer2_control_capture_reload;
  logic               ref_clk, rst_n, avs_read, avs_write, six_clock_mode, timer_irq_enable;
  logic               trig_go, cnt_run, avs_waitrequest, timer_irq_req, irq, ext_pin, cnt_pin;
  logic [7:0]         avs_address;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_writedata, avs_readdata;
  logic [15:0]        rnd;
  t2c_pkg::t2c_baud_s baud_q;
  int                 rx_ticks, tx_ticks, miscompares, comparisons;
  logic [31:0]        exp_q[$];

  t2c_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_trigger_pin(ext_pin),
    .count_pin(cnt_pin), .six_clock_mode(six_clock_mode), .timer_irq_enable(timer_irq_enable),
    .timer_irq_req(timer_irq_req), .irq(irq), .baud_q(baud_q));
  t2c_far far_u (.ref_clk(ref_clk), .trig_go(trig_go), .cnt_run(cnt_run), .baud_q(baud_q),
    .trig_pin(ext_pin), .cnt_pin(cnt_pin), .rx_ticks(rx_ticks), .tx_ticks(tx_ticks));

  // ==========================================================================
  // checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_address   <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (!avs_waitrequest) break;
    end
    if (n == 20) begin
      miscompares++;
      results();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // two idle edges so registered outputs have followed a write that landed at the answer edge
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask
  task automatic wait_irq(input int bound);
    int n;
    for (n = 0; n < bound && irq !== 1'b1; n++) @(posedge ref_clk);
    if (n == bound) begin
      miscompares++;
      results();
    end
  endtask
  task automatic trigger();
    trig_go <= 1'b1;
    @(posedge ref_clk);
    trig_go <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask
  // the watcher pairs each answered read with the oldest expectation
  always @(posedge ref_clk) begin
    if (avs_read && !avs_waitrequest) check("readdata", avs_readdata, exp_q.pop_front());
  end

  // ==========================================================================
  // clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, avs_read, avs_write, trig_go, cnt_run, avs_address, avs_writedata} = '0;
    {six_clock_mode, timer_irq_enable, avs_byteenable} = 6'h3F;
    {miscompares, comparisons} = '0;
    void'($urandom(59));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(t2c_pkg::ADDR_CONTROL, 32'h00);
    rd(8'hE0, 32'h0);
    rd(t2c_pkg::ADDR_IRQ_CLR, 32'h0);
    wr(t2c_pkg::ADDR_IRQ_EN, 32'h3);
    wr(t2c_pkg::ADDR_HOLD, 32'hFFF0);
    wr(t2c_pkg::ADDR_COUNT, 32'hFFF0);
    wr(t2c_pkg::ADDR_CONTROL, 32'h04);
    wait_irq(110);
    rd(t2c_pkg::ADDR_CONTROL, 32'h84);
    check("timer_irq_req", timer_irq_req, 1'b1);
    wr(t2c_pkg::ADDR_CONTROL, 32'h00);
    rd(t2c_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(t2c_pkg::ADDR_IRQ_CLR, 32'h3);
    check("irq", irq, 1'b0);
    rnd = 16'($urandom);
    wr(t2c_pkg::ADDR_COUNT, {16'h0, rnd});
    repeat (50) @(posedge ref_clk);
    rd(t2c_pkg::ADDR_COUNT, {16'h0, rnd});
    wr(t2c_pkg::ADDR_IRQ_EN, 32'h1);
    wr(t2c_pkg::ADDR_CONTROL, 32'h09);
    trigger();
    rd(t2c_pkg::ADDR_HOLD, {16'h0, rnd});
    rd(t2c_pkg::ADDR_CONTROL, 32'h49);
    check("timer_irq_req", timer_irq_req, 1'b1);
    timer_irq_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("timer_irq_req", timer_irq_req, 1'b0);
    timer_irq_enable <= 1'b1;
    check("irq", irq, 1'b0);
    wr(t2c_pkg::ADDR_IRQ_EN, 32'h3);
    check("irq", irq, 1'b1);
    wr(t2c_pkg::ADDR_MODE, 32'h1);
    check("timer_irq_req", timer_irq_req, 1'b0);
    rd(t2c_pkg::ADDR_CONTROL, 32'h49);
    wr(t2c_pkg::ADDR_MODE, 32'h0);
    wr(t2c_pkg::ADDR_IRQ_CLR, 32'h3);
    wr(t2c_pkg::ADDR_CONTROL, 32'h08);
    wr(t2c_pkg::ADDR_COUNT, 32'h0);
    trigger();
    rd(t2c_pkg::ADDR_COUNT, {16'h0, rnd});
    rd(t2c_pkg::ADDR_CONTROL, 32'h48);
    wr(t2c_pkg::ADDR_CONTROL, 32'h00);
    wr(t2c_pkg::ADDR_COUNT, 32'h55);
    trigger();
    rd(t2c_pkg::ADDR_COUNT, 32'h55);
    wr(t2c_pkg::ADDR_IRQ_CLR, 32'h3);
    wr(t2c_pkg::ADDR_HOLD, 32'hFFF8);
    wr(t2c_pkg::ADDR_COUNT, 32'hFFF8);
    wr(t2c_pkg::ADDR_CONTROL, 32'h3D);
    trigger();
    repeat (300) @(posedge ref_clk);
    rd(t2c_pkg::ADDR_CONTROL, 32'h3D);
    check("rx_ticks_seen", 32'(rx_ticks >= 4), 32'h1);
    check("tx_ticks", tx_ticks, rx_ticks);
    wr(t2c_pkg::ADDR_CONTROL, 32'h00);
    wr(t2c_pkg::ADDR_IRQ_CLR, 32'h3);
    wr(t2c_pkg::ADDR_COUNT, 32'hFFFC);
    wr(t2c_pkg::ADDR_CONTROL, 32'h06);
    repeat (100) @(posedge ref_clk);
    check("irq", irq, 1'b0);
    cnt_run <= 1'b1;
    wait_irq(100);
    rd(t2c_pkg::ADDR_CONTROL, 32'h86);
    cnt_run <= 1'b0;
    wr(t2c_pkg::ADDR_CONTROL, 32'h00);
    wr(t2c_pkg::ADDR_IRQ_CLR, 32'h3);
    six_clock_mode <= 1'b0;
    wr(t2c_pkg::ADDR_COUNT, 32'hFFF0);
    wr(t2c_pkg::ADDR_CONTROL, 32'h04);
    repeat (150) @(posedge ref_clk);
    check("irq", irq, 1'b0);
    wait_irq(100);
    results();
  end
endmodule
